// File: shared/psc_pkg.sv
// constants and carriers of the processor status and control register
package psc_pkg;
    localparam int unsigned CLK_MHZ = 20;
    localparam int unsigned AXI_AW = 12;
    localparam logic [AXI_AW-1:0] PSC_IDX = 12'h0FF;
    localparam logic [AXI_AW-1:0] ACT_IDX = 12'h001;
    localparam int unsigned B_RUN = 0;
    localparam int unsigned B_STEP = 1;
    localparam int unsigned B_MASK = 2;
    localparam int unsigned B_SUSP = 3;
    localparam int unsigned B_PU = 4;
    localparam int unsigned B_BUSRST = 5;
    localparam int unsigned B_WDT = 6;
    localparam int unsigned B_IRQ = 7;
    localparam logic [7:0] PSC_POR_VAL = 8'h11;
    localparam logic [7:0] PSC_WDR_VAL = 8'h41;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int unsigned SE0_NS = 8000;
    localparam int unsigned SE0_CYC = (SE0_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SHORT_NS = 128000;
    localparam int unsigned SHORT_CYC = (SHORT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned LONG_MS = 96;
    localparam int unsigned LONG_CYC = LONG_MS * CLK_MHZ * 1000;
    localparam int unsigned DLY_W = 21;

    typedef struct packed {
        logic awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_AW-1:0] araddr;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;

    typedef struct packed {
        logic halt_exec;
        logic instr_done;
        logic irq_off_instruction;
        logic irq_on_instruction;
        logic return_from_irq_instruction;
        logic irq_seen;
        logic irq_ack;
    } core_evt_s;

    typedef enum logic [1:0] {ST_RUN, ST_SUSPEND, ST_WAKE} susp_e;
endpackage : psc_pkg

// File: rtl/processor_status_control_reg.sv
// processor status and control register with AXI4-Lite access
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module processor_status_control_reg #(
    parameter int unsigned LONG_DELAY = psc_pkg::LONG_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire psc_pkg::axi_req_s axi_req,
    output var psc_pkg::axi_rsp_s axi_rsp,
    input wire psc_pkg::core_evt_s core_evt,
    input wire logic watchdog_reset,
    input wire logic usb_serial_engine_activity,
    input wire logic usb_dp_pin,
    input wire logic usb_dm_pin,
    input wire logic port3_bit7_pin,
    output logic cpu_go,
    output logic suspend_mode,
    output logic irq_enabled,
    output logic bus_reset_irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] dp_sync;
        logic [1:0] dm_sync;
        logic [1:0] p37_sync;
        logic [7:0] se0_cnt;
        logic [psc_pkg::DLY_W-1:0] dly_cnt;
        psc_pkg::susp_e st;
        logic run;
        logic step;
        logic int_en;
        logic pu_flag;
        logic busrst;
        logic wdt_flag;
        logic irq_pend;
        logic activity;
        logic aw_got;
        logic w_got;
        logic [psc_pkg::AXI_AW-1:0] waddr;
        logic [7:0] wbyte;
        logic wlane;
        logic cpu_go;
        logic busrst_irq;
        logic susp;
        psc_pkg::axi_rsp_s rsp;
    } state_s;

    state_s q;
    state_s d;
    logic wr_fire;
    logic wr_psc;
    logic se0_now;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.busrst_irq = 1'b0;
        d.dp_sync = {q.dp_sync[0], usb_dp_pin};
        d.dm_sync = {q.dm_sync[0], usb_dm_pin};
        d.p37_sync = {q.p37_sync[0], port3_bit7_pin};
        se0_now = ~q.dp_sync[1] & ~q.dm_sync[1];

        // bus reset: SE0 held beyond the limit, interrupt only
        if (!se0_now) begin
            d.se0_cnt = 8'h00;
        end else if (q.se0_cnt <= psc_pkg::SE0_CYC[7:0]) begin
            d.se0_cnt = q.se0_cnt + 8'h01;
        end
        if (se0_now && q.se0_cnt == psc_pkg::SE0_CYC[7:0]) begin
            d.busrst = 1'b1;
            d.busrst_irq = 1'b1;
        end

        // interrupt enable, only from instructions and acknowledge
        if (core_evt.irq_off_instruction || core_evt.irq_ack) begin
            d.int_en = 1'b0;
        end else if (core_evt.irq_on_instruction || core_evt.return_from_irq_instruction) begin
            d.int_en = 1'b1;
        end
        if (core_evt.irq_ack) begin
            d.irq_pend = 1'b0;
        end

        // AXI write path
        if (axi_req.awvalid && q.rsp.awready) begin
            d.aw_got = 1'b1;
            d.waddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && q.rsp.wready) begin
            d.w_got = 1'b1;
            d.wbyte = axi_req.wdata[7:0];
            d.wlane = axi_req.wstrb[0];
        end
        wr_fire = q.aw_got && q.w_got && !q.rsp.bvalid;
        wr_psc = wr_fire && q.wlane && q.waddr[psc_pkg::AXI_AW-1:2] == psc_pkg::PSC_IDX[9:0];
        if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp = psc_pkg::RESP_OK;
            if (q.waddr[psc_pkg::AXI_AW-1:2] == psc_pkg::ACT_IDX[9:0]) begin
                if (q.wlane && !q.wbyte[0]) begin
                    d.activity = 1'b0;
                end
            end else if (q.waddr[psc_pkg::AXI_AW-1:2] != psc_pkg::PSC_IDX[9:0]) begin
                d.rsp.bresp = psc_pkg::RESP_SLVERR;
            end
        end
        if (wr_psc) begin
            // mask and pending bits are not writable
            d.run = q.run & q.wbyte[psc_pkg::B_RUN];
            d.step = q.wbyte[psc_pkg::B_STEP];
            d.pu_flag = q.pu_flag & q.wbyte[psc_pkg::B_PU];
            d.wdt_flag = q.wdt_flag & q.wbyte[psc_pkg::B_WDT];
            d.busrst = d.busrst & (q.wbyte[psc_pkg::B_BUSRST] | se0_now);
            if (q.wbyte[psc_pkg::B_SUSP] && !q.activity && !q.irq_pend
                    && q.st == psc_pkg::ST_RUN) begin
                d.st = psc_pkg::ST_SUSPEND;
            end
        end
        if (q.rsp.bvalid && axi_req.bready) begin
            d.rsp.bvalid = 1'b0;
        end

        // hardware sets win over software clears
        if (core_evt.irq_seen) begin
            d.irq_pend = 1'b1;
        end
        if (usb_serial_engine_activity) begin
            d.activity = 1'b1;
        end

        // halt stops at once on halt_exec, single step stops at the end of an instruction
        if (core_evt.halt_exec) begin
            d.run = 1'b0;
        end
        if (core_evt.instr_done && q.step) begin
            d.run = 1'b0;
        end

        // suspend and wake with start-up delay
        case (q.st)
            psc_pkg::ST_RUN: begin
                d.dly_cnt = '0;
            end
            psc_pkg::ST_SUSPEND: begin
                if (q.irq_pend || q.activity) begin
                    d.st = psc_pkg::ST_WAKE;
                    if (q.p37_sync[1] || !q.pu_flag) begin
                        d.dly_cnt = psc_pkg::SHORT_CYC[psc_pkg::DLY_W-1:0];
                    end else begin
                        d.dly_cnt = LONG_DELAY[psc_pkg::DLY_W-1:0];
                    end
                end
            end
            psc_pkg::ST_WAKE: begin
                if (q.dly_cnt <= 1) begin
                    d.st = psc_pkg::ST_RUN;
                    d.dly_cnt = '0;
                end else begin
                    d.dly_cnt = q.dly_cnt - 1'b1;
                end
            end
            default: begin
                d.st = psc_pkg::ST_RUN;
            end
        endcase

        // AXI read path
        if (axi_req.arvalid && q.rsp.arready) begin
            d.rsp.rvalid = 1'b1;
            d.rsp.rresp = psc_pkg::RESP_OK;
            d.rsp.rdata = 32'h0000_0000;
            if (axi_req.araddr[psc_pkg::AXI_AW-1:2] == psc_pkg::PSC_IDX[9:0]) begin
                d.rsp.rdata[7:0] = {q.irq_pend, q.wdt_flag, q.busrst, q.pu_flag,
                                    q.st != psc_pkg::ST_RUN, q.int_en, q.step, q.run};
            end else if (axi_req.araddr[psc_pkg::AXI_AW-1:2] == psc_pkg::ACT_IDX[9:0]) begin
                d.rsp.rdata[0] = q.activity;
            end else begin
                d.rsp.rresp = psc_pkg::RESP_SLVERR;
            end
        end else if (q.rsp.rvalid && axi_req.rready) begin
            d.rsp.rvalid = 1'b0;
        end
        d.rsp.arready = !d.rsp.rvalid;
        d.rsp.awready = !d.aw_got && !d.rsp.bvalid;
        d.rsp.wready = !d.w_got && !d.rsp.bvalid;
        d.cpu_go = d.run && d.st == psc_pkg::ST_RUN;
        d.susp = d.st != psc_pkg::ST_RUN;
    end

    // ------------------------------------------------------------
    // registers and resets
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.run <= psc_pkg::PSC_POR_VAL[psc_pkg::B_RUN];
            q.pu_flag <= psc_pkg::PSC_POR_VAL[psc_pkg::B_PU];
            q.st <= psc_pkg::ST_RUN;
            q.dm_sync <= 2'h3;
        end else if (watchdog_reset) begin
            q <= '0;
            q.run <= psc_pkg::PSC_WDR_VAL[psc_pkg::B_RUN];
            q.wdt_flag <= psc_pkg::PSC_WDR_VAL[psc_pkg::B_WDT];
            q.st <= psc_pkg::ST_RUN;
            q.dm_sync <= 2'h3;
        end else begin
            q <= d;
        end
    end

    assign axi_rsp = q.rsp;
    assign cpu_go = q.cpu_go;
    assign suspend_mode = q.susp;
    assign irq_enabled = q.int_en;
    assign bus_reset_irq = q.busrst_irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || watchdog_reset);

    sequence susp_req;
        wr_psc && q.wbyte[psc_pkg::B_SUSP] && !q.activity && !q.irq_pend
            && q.st == psc_pkg::ST_RUN;
    endsequence
    sequence susp_entered;
        q.st == psc_pkg::ST_SUSPEND ##1 !q.cpu_go;
    endsequence

    a_halt_stops_run: assert property (core_evt.halt_exec |=> !q.run ##1 !cpu_go)
        else $error("halt did not stop the core");
    a_halt_sticks: assert property (!q.run |=> !q.run)
        else $error("run set again without reset");
    a_step_halts: assert property (q.step && core_evt.instr_done |=> !q.run)
        else $error("single step did not halt");
    a_mask_by_instr: assert property (core_evt.irq_on_instruction && !core_evt.irq_ack
        && !core_evt.irq_off_instruction |=> q.int_en ##1 irq_enabled)
        else $error("irq on instruction did not enable");
    a_suspend_enter: assert property (susp_req |=> susp_entered)
        else $error("suspend request not taken");
    a_suspend_refused: assert property (wr_psc && (q.activity || q.irq_pend)
        && q.st == psc_pkg::ST_RUN |=> q.st == psc_pkg::ST_RUN)
        else $error("suspend taken despite pending event");
    a_pu_only_por: assert property (!q.pu_flag |=> !q.pu_flag)
        else $error("power-up flag set outside power-on reset");
    a_bus_reset_flag: assert property (se0_now && q.se0_cnt == psc_pkg::SE0_CYC[7:0]
        |=> q.busrst && q.busrst_irq ##1 !q.busrst_irq && q.run == $past(q.run))
        else $error("bus reset not flagged after long SE0");
    a_irq_set_wins: assert property (core_evt.irq_seen |=> q.irq_pend)
        else $error("irq pending lost");
    a_wake_delay: assert property (q.st == psc_pkg::ST_SUSPEND
        && (q.irq_pend || q.activity) && (q.p37_sync[1] || !q.pu_flag)
        |=> q.st == psc_pkg::ST_WAKE
        && q.dly_cnt == psc_pkg::SHORT_CYC[psc_pkg::DLY_W-1:0])
        else $error("wrong wake delay");
    a_run_kept: assert property (q.run && !wr_psc && !core_evt.halt_exec
        && !(q.step && core_evt.instr_done) |=> q.run)
        else $error("run cleared without halt, step or write");
    a_step_held: assert property (!wr_psc |=> $stable(q.step))
        else $error("single step changed without a write");

    // ------------------------------------------------------------
    // checks: interrupt state
    // ------------------------------------------------------------
    sequence no_ie_evt;
        !core_evt.irq_off_instruction && !core_evt.irq_on_instruction
            && !core_evt.return_from_irq_instruction && !core_evt.irq_ack;
    endsequence

    a_int_en_quiet: assert property (no_ie_evt |=> $stable(q.int_en))
        else $error("irq enable changed without an instruction");
    a_irq_off_clears: assert property (core_evt.irq_off_instruction |=> !q.int_en)
        else $error("irq off instruction did not disable");
    a_return_from_irq_instruction_enables: assert property (core_evt.return_from_irq_instruction
        && !core_evt.irq_off_instruction && !core_evt.irq_ack |=> q.int_en)
        else $error("return from irq did not enable");
    a_pend_held: assert property (!core_evt.irq_seen && !core_evt.irq_ack
        |=> $stable(q.irq_pend))
        else $error("irq pending changed without an event");
    a_ack_clears: assert property (core_evt.irq_ack && !core_evt.irq_seen
        |=> !q.irq_pend)
        else $error("acknowledge did not clear irq pending");

    // ------------------------------------------------------------
    // checks: reset causes, bus reset and activity
    // ------------------------------------------------------------
    a_wdt_only_reset: assert property (!q.wdt_flag |=> !q.wdt_flag)
        else $error("watchdog flag set outside watchdog reset");
    a_pu_kept: assert property (q.pu_flag && !wr_psc |=> q.pu_flag)
        else $error("power-up flag lost without a write");
    a_busrst_only_se0: assert property (!q.busrst
        && !(se0_now && q.se0_cnt == psc_pkg::SE0_CYC[7:0]) |=> !q.busrst)
        else $error("bus reset flag set without long SE0");
    a_bus_irq_pulse: assert property (bus_reset_irq |=> !bus_reset_irq)
        else $error("bus reset interrupt longer than one cycle");
    a_short_se0_quiet: assert property (!se0_now |=> !q.busrst_irq)
        else $error("bus reset interrupt without SE0");
    a_activity_set: assert property (usb_serial_engine_activity |=> q.activity)
        else $error("bus activity not recorded");
    a_activity_sticky: assert property (q.activity && !wr_fire |=> q.activity)
        else $error("bus activity lost without a write");
    a_activity_no_sw: assert property (!q.activity && !usb_serial_engine_activity
        |=> !q.activity)
        else $error("bus activity set by software");

    // ------------------------------------------------------------
    // checks: suspend and wake
    // ------------------------------------------------------------
    sequence quiet_suspend;
        q.st == psc_pkg::ST_SUSPEND && !q.irq_pend && !q.activity;
    endsequence
    sequence wake_ending;
        q.st == psc_pkg::ST_WAKE && q.dly_cnt <= 1;
    endsequence

    a_suspend_holds: assert property (quiet_suspend
        |=> q.st == psc_pkg::ST_SUSPEND && !cpu_go)
        else $error("suspend left without a wake event");
    a_wake_on_event: assert property (q.st == psc_pkg::ST_SUSPEND
        && (q.irq_pend || q.activity) |=> q.st == psc_pkg::ST_WAKE)
        else $error("wake event did not start the delay");
    a_wake_long: assert property (q.st == psc_pkg::ST_SUSPEND
        && (q.irq_pend || q.activity) && !q.p37_sync[1] && q.pu_flag
        |=> q.dly_cnt == LONG_DELAY[psc_pkg::DLY_W-1:0])
        else $error("long start-up delay not chosen");
    a_wake_counts: assert property (q.st == psc_pkg::ST_WAKE && q.dly_cnt > 1
        |=> q.st == psc_pkg::ST_WAKE && q.dly_cnt == $past(q.dly_cnt) - 1)
        else $error("start-up delay did not count down");
    a_wake_finishes: assert property (wake_ending
        |=> q.st == psc_pkg::ST_RUN && !suspend_mode)
        else $error("wake delay did not end");
    a_wake_resumes: assert property (q.st == psc_pkg::ST_WAKE && q.dly_cnt <= 1 && q.run
        && !core_evt.halt_exec && !core_evt.instr_done |=> cpu_go)
        else $error("core did not resume after wake");
    a_no_go_suspended: assert property (suspend_mode |-> !cpu_go)
        else $error("core running while suspended");
endmodule : processor_status_control_reg
`default_nettype wire

// File: dv/usb_line_model.sv
// behavioural model of the usb lines and the engine activity report
`timescale 1ns/10ps
`default_nettype none
module usb_line_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic se0_req,
    input wire logic k_req,
    output logic dp,
    output logic dm,
    output logic activity
);
    // ------
    // line states
    // ------
    logic busy_q;

    // idle j is dm high, dp low; activity pulses once per non-idle spell
    always @(posedge aclk) begin
        if (!aresetn) begin
            dp <= 1'b0;
            dm <= 1'b1;
            activity <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            dp <= k_req;
            dm <= !(se0_req || k_req);
            activity <= (se0_req || k_req) && !busy_q;
            busy_q <= se0_req || k_req;
        end
    end
endmodule : usb_line_model
`default_nettype wire

// File: dv/processor_status_control_reg_tb_top.sv
// self-checking bench of the processor status and control register
`timescale 1ns/10ps
`default_nettype none
module processor_status_control_reg_tb_top;
    // ------
    // signals
    // ------
    localparam logic [11:0] PSC = 12'h3FC;
    localparam logic [11:0] ACT = 12'h004;
    localparam logic [6:0] E_HALT = 7'h40;
    localparam logic [6:0] E_DONE = 7'h20;
    localparam logic [6:0] E_OFF = 7'h10;
    localparam logic [6:0] E_ON = 7'h08;
    localparam logic [6:0] E_RETURN_FROM_IRQ_INSTRUCTION = 7'h04;
    localparam logic [6:0] E_SEEN = 7'h02;
    localparam logic [6:0] E_ACK = 7'h01;
    localparam logic [1:0] ERR = psc_pkg::RESP_SLVERR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    psc_pkg::axi_req_s req = '0;
    psc_pkg::axi_rsp_s rsp;
    psc_pkg::core_evt_s evt = '0;
    logic wdr = 1'b0;
    logic se0 = 1'b0;
    logic kreq = 1'b0;
    logic p3 = 1'b0;
    logic act, dp, dm, cpu_go, suspend_mode, irq_enabled, bus_reset_irq;
    logic [33:0] exp_q[$];
    int miscompares = 0;
    int total_checks = 0;
    int seed = 25728;

    always #25 aclk = ~aclk;

    processor_status_control_reg #(.LONG_DELAY(50)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .axi_req(req), .axi_rsp(rsp), .core_evt(evt), .watchdog_reset(wdr),
        .usb_serial_engine_activity(act), .usb_dp_pin(dp), .usb_dm_pin(dm),
        .port3_bit7_pin(p3), .cpu_go(cpu_go), .suspend_mode(suspend_mode),
        .irq_enabled(irq_enabled), .bus_reset_irq(bus_reset_irq));

    usb_line_model i_usb (.aclk(aclk), .aresetn(aresetn), .se0_req(se0), .k_req(kreq),
        .dp(dp), .dm(dm), .activity(act));

    // ------
    // tasks
    // ------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    task automatic hang();
        miscompares++;
        wrap_up();
    endtask : hang

    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic done(input string t);
        $display("test %s finished", t);
    endtask : done

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF, input logic [1:0] er = 2'h0);
        int n;
        exp_q.push_back({er, 32'h0});
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= s;
        req.bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid && req.bready) break;
        end
        req.bready <= 1'b0;
        if (n == 100) hang();
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er = 2'h0);
        int n;
        exp_q.push_back({er, 24'h0, e});
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid && req.rready) break;
        end
        req.rready <= 1'b0;
        if (n == 100) hang();
    endtask : rd

    task automatic ev(input logic [6:0] v);
        @(posedge aclk);
        evt <= v;
        @(posedge aclk);
        evt <= '0;
    endtask : ev

    task automatic wait_sig(input int sel, input int lim, output int n);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (n > lim) hang();
        end while (sel == 0 ? bus_reset_irq !== 1'b1 : suspend_mode !== 1'b0);
    endtask : wait_sig

    // ------
    // response monitor
    // ------
    always @(posedge aclk) begin
        if ((rsp.rvalid && req.rready) || (rsp.bvalid && req.bready)) begin
            if (exp_q.size() == 0) begin
                hang();
            end else if (rsp.rvalid && req.rready) begin
                chk("read", {rsp.rresp, rsp.rdata}, exp_q.pop_front());
            end else begin
                chk("write resp", {rsp.bresp, 32'h0}, exp_q.pop_front());
            end
        end
    end

    // ------
    // main sequence
    // ------
    initial begin
        int n;
        logic [31:0] r;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(PSC, 8'h11);
        chk("cpu_go", 34'(cpu_go), 34'h1);
        wr(PSC, 32'hF7);
        rd(PSC, 8'h13);
        r = $random(seed);
        wr(PSC, r, 4'hE);
        rd(PSC, 8'h13);
        wr(PSC, 32'h11);
        r = $random(seed);
        rd(12'h008 + (r[11:0] & 12'h3F0), 8'h00, ERR);
        wr(12'h008 + (r[11:0] & 12'h3F0), r, 4'hF, ERR);
        rd(PSC, 8'h11);
        done("register access");
        ev(E_ON);
        rd(PSC, 8'h15);
        chk("irq_enabled", 34'(irq_enabled), 34'h1);
        ev(E_OFF);
        rd(PSC, 8'h11);
        ev(E_RETURN_FROM_IRQ_INSTRUCTION);
        rd(PSC, 8'h15);
        ev(E_ACK);
        rd(PSC, 8'h11);
        ev(E_SEEN);
        rd(PSC, 8'h91);
        wr(PSC, 32'h19);
        repeat (3) @(posedge aclk);
        chk("suspend_mode", 34'(suspend_mode), 34'h0);
        ev(E_ACK);
        rd(PSC, 8'h11);
        done("interrupt state");
        se0 <= 1'b1;
        wait_sig(0, 400, n);
        chk("se0 time", 34'(n >= 161 && n <= 175), 34'h1);
        chk("cpu_go", 34'(cpu_go), 34'h1);
        se0 <= 1'b0;
        rd(PSC, 8'h31);
        wr(PSC, 32'hD1);
        rd(PSC, 8'h11);
        done("bus reset");
        rd(ACT, 8'h01);
        wr(PSC, 32'h19);
        repeat (3) @(posedge aclk);
        chk("suspend_mode", 34'(suspend_mode), 34'h0);
        wr(ACT, 32'h0);
        rd(ACT, 8'h00);
        for (int i = 0; i < 3; i++) begin
            int dly;
            dly = (i == 0) ? 50 : 2560;
            wr(PSC, 32'h19);
            repeat (20) @(posedge aclk);
            chk("suspend_mode", 34'(suspend_mode), 34'h1);
            chk("cpu_go", 34'(cpu_go), 34'h0);
            kreq <= 1'b1;
            wait_sig(1, 3000, n);
            kreq <= 1'b0;
            chk("wake time", 34'(n >= dly && n <= dly + 12), 34'h1);
            repeat (2) @(posedge aclk);
            chk("cpu_go", 34'(cpu_go), 34'h1);
            rd(PSC, (i == 2) ? 8'h01 : 8'h11);
            wr(ACT, 32'h0);
            if (i == 1) begin
                wr(PSC, 32'h01);
            end
            p3 <= (i == 0);
        end
        done("suspend and wake");
        ev(E_HALT);
        repeat (2) @(posedge aclk);
        chk("cpu_go", 34'(cpu_go), 34'h0);
        rd(PSC, 8'h00);
        wr(PSC, 32'h11);
        rd(PSC, 8'h00);
        wdr <= 1'b1;
        repeat (2) @(posedge aclk);
        wdr <= 1'b0;
        repeat (2) @(posedge aclk);
        rd(PSC, 8'h41);
        chk("cpu_go", 34'(cpu_go), 34'h1);
        wr(PSC, 32'h43);
        ev(E_DONE);
        repeat (2) @(posedge aclk);
        chk("cpu_go", 34'(cpu_go), 34'h0);
        rd(PSC, 8'h42);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(PSC, 8'h11);
        done("halt and resets");
        wrap_up();
    end
endmodule : processor_status_control_reg_tb_top
`default_nettype wire
